//--- design/system_setup_latches.sv
// Purpose: startup setup latches, memory placement and time protected options
// Assumes: AXI4-Lite register access on aclk; mode pins are asynchronous
// Notes: the stored setup byte keeps its value across aresetn; por_n sets it
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
module system_setup_latches
    import setup_latch_pkg::*;
#(
    parameter bit REMAP_VARIANT = 1'b0,
    parameter bit SECURITY_OPTION = 1'b1,
    parameter logic [7:0] NV_INIT = NV_DEFAULT
)
(
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic por_n,
    // mode pins, test control and processor address
    input wire logic boot_pin_b,
    input wire logic mode_pin_a,
    input wire logic test_disable_resets,
    input wire logic [15:0] cpu_addr,
    // axi4-lite write
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // configuration outputs
    output logic rom_in_map,
    output logic nvm_in_map,
    output logic security_disable,
    output logic watchdog_enable,
    output logic irq_edge_only,
    output logic osc_startup_delay,
    output logic [1:0] watchdog_rate,
    output logic converter_power_up,
    output logic pump_clock_alt,
    output logic adc_clock_alt,
    output logic special_mode_flag,
    // memory selects
    output logic ram_sel,
    output logic reg_sel,
    output logic rom_sel,
    output logic nvm_sel,
    output logic ext_sel
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic boot_b_s1_reg, boot_b_s2_reg, mode_a_s1_reg, mode_a_s2_reg;
    logic [7:0] nv_reg, setup_latch_reg, placement_reg, choices_reg;
    logic special_reg, mode_a_reg, placement_done_reg, choices_done_reg, wdog_prev_reg;
    logic [6:0] cycle_cnt_reg;
    logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg, rd_setup_reg;
    logic [13:0] widx_reg;
    logic [7:0] wbyte_reg;
    logic wlane_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic window_open, single_chip, do_write, wr_mapped, rd_mapped;
    logic [13:0] ridx;
    logic [7:0] setup_next, setup_read, choices_next;
    logic placement_allowed, protected_allowed;
    logic ram_sel_d, reg_sel_d, rom_sel_d, nvm_sel_d, ext_sel_d;

    function automatic logic idx_mapped(input logic [13:0] idx);
        idx_mapped = (idx == IDX_SETUP) || (idx == IDX_PLACEMENT)
            || (idx == IDX_CHOICES) || (idx == IDX_STATUS);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (ce)
        begin
            boot_b_s1_reg <= boot_pin_b;
            boot_b_s2_reg <= boot_b_s1_reg;
            mode_a_s1_reg <= mode_pin_a;
            mode_a_s2_reg <= mode_a_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // reload value of the working latches
    // ------------------------------------------------------------
    always_comb
    begin
        setup_next = nv_reg;
        if (!REMAP_VARIANT)
            setup_next[7:4] = 4'h0;
        if (!boot_b_s2_reg)
            setup_next[SETUP_WDOG_DIS] = wdog_prev_reg;
        if (mode_a_s2_reg || !SECURITY_OPTION)
            setup_next[SETUP_SEC_DIS] = 1'b1;
        if (REMAP_VARIANT && !mode_a_s2_reg)
        begin
            setup_next[7:4] = PAGE_ALL_ONES;
            setup_next[SETUP_NVM_EN] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // mode capture and working latches
    // ------------------------------------------------------------
    // reset acts regardless of ce so the latches always reload
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            special_reg <= ~boot_b_s2_reg;
            mode_a_reg <= mode_a_s2_reg;
            setup_latch_reg <= setup_next;
        end
    end

    // copy taken outside reset: the early reset cycles still see the old
    // mode pins and would otherwise overwrite the latch before it is kept
    always_ff @(posedge aclk)
    begin
        if (aresetn && ce)
            wdog_prev_reg <= setup_latch_reg[SETUP_WDOG_DIS];
    end

    // the stored byte survives aresetn; only power-on restores it
    always_ff @(posedge aclk)
    begin
        if (!por_n)
            nv_reg <= NV_INIT;
        else if (ce && do_write && widx_reg == IDX_SETUP && wlane_reg)
            nv_reg <= wbyte_reg;
    end

    // ------------------------------------------------------------
    // protection window
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cycle_cnt_reg <= 7'h00;
        else if (ce && cycle_cnt_reg != WINDOW_COUNT)
            cycle_cnt_reg <= cycle_cnt_reg + 7'h01;
    end

    assign window_open = cycle_cnt_reg < WINDOW_COUNT;
    assign single_chip = !special_reg && !mode_a_reg;
    assign placement_allowed = special_reg || (window_open && !placement_done_reg);
    assign protected_allowed = special_reg || (window_open && !choices_done_reg);

    // ------------------------------------------------------------
    // placement and options registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            placement_reg <= PLACEMENT_RESET;
            placement_done_reg <= 1'b0;
        end
        else if (ce && do_write && widx_reg == IDX_PLACEMENT && wlane_reg
            && placement_allowed)
        begin
            placement_reg <= wbyte_reg;
            placement_done_reg <= !special_reg;
        end
    end

    always_comb
    begin
        choices_next = (choices_reg & CHOICES_PROTECTED) | (wbyte_reg & ~CHOICES_PROTECTED);
        if (protected_allowed)
            choices_next = wbyte_reg;
        choices_next = choices_next & CHOICES_IMPL;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            choices_reg <= CHOICES_RESET;
            choices_done_reg <= 1'b0;
        end
        else if (ce && do_write && widx_reg == IDX_CHOICES && wlane_reg)
        begin
            // late protected writes drop quietly; free bits still land
            choices_reg <= choices_next;
            if (protected_allowed && !special_reg)
                choices_done_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    assign awready = ce && !aw_hold_reg && !bvalid_reg;
    assign wready = ce && !w_hold_reg && !bvalid_reg;
    assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
    assign wr_mapped = idx_mapped(widx_reg);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            widx_reg <= 14'h0000;
            wbyte_reg <= 8'h00;
            wlane_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (awvalid && awready)
            begin
                aw_hold_reg <= 1'b1;
                widx_reg <= awaddr[ADDR_W-1:2];
            end
            if (wvalid && wready)
            begin
                w_hold_reg <= 1'b1;
                wbyte_reg <= wdata[7:0];
                wlane_reg <= wstrb[0];
            end
            if (do_write)
            begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_reg && bready)
                bvalid_reg <= 1'b0;
        end
    end

    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    assign arready = ce && !rvalid_reg;
    assign ridx = araddr[ADDR_W-1:2];
    assign rd_mapped = idx_mapped(ridx);
    assign setup_read = setup_latch_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
            rd_setup_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (arvalid && arready)
            begin
                rvalid_reg <= 1'b1;
                rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
                rd_setup_reg <= ridx == IDX_SETUP;
                case (ridx)
                    IDX_SETUP: rdata_reg <= {24'h000000, setup_read};
                    IDX_PLACEMENT: rdata_reg <= {24'h000000, placement_reg};
                    IDX_CHOICES: rdata_reg <= {24'h000000, choices_reg};
                    IDX_STATUS: rdata_reg <= {16'h0000, nv_reg, 3'h0, choices_done_reg,
                        placement_done_reg, window_open, mode_a_reg, special_reg};
                    default: rdata_reg <= 32'h0000_0000;
                endcase
            end
            else if (rvalid_reg && rready)
                rvalid_reg <= 1'b0;
        end
    end

    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    // ------------------------------------------------------------
    // memory map decode and registered outputs
    // ------------------------------------------------------------
    mem_map_decode #(
        .REMAP_VARIANT(REMAP_VARIANT)
    ) u_decode (
        .cpu_addr(cpu_addr),
        .setup_latch(setup_latch_reg),
        .rom_in_map(rom_in_map),
        .placement(placement_reg),
        .ram_sel(ram_sel_d),
        .reg_sel(reg_sel_d),
        .rom_sel(rom_sel_d),
        .nvm_sel(nvm_sel_d),
        .ext_sel(ext_sel_d)
    );

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rom_in_map <= 1'b0;
            nvm_in_map <= 1'b0;
            security_disable <= 1'b1;
            watchdog_enable <= 1'b0;
            irq_edge_only <= 1'b0;
            osc_startup_delay <= 1'b0;
            watchdog_rate <= 2'h0;
            converter_power_up <= 1'b0;
            pump_clock_alt <= 1'b0;
            adc_clock_alt <= 1'b0;
            special_mode_flag <= 1'b0;
            {ram_sel, reg_sel, rom_sel, nvm_sel, ext_sel} <= 5'h00;
        end
        else if (ce)
        begin
            rom_in_map <= setup_latch_reg[SETUP_ROM_EN] || single_chip;
            nvm_in_map <= setup_latch_reg[SETUP_NVM_EN];
            security_disable <= setup_latch_reg[SETUP_SEC_DIS];
            // special modes hand watchdog control to the test input
            watchdog_enable <= special_reg ? !test_disable_resets
                : !setup_latch_reg[SETUP_WDOG_DIS];
            irq_edge_only <= choices_reg[OPT_IRQ_EDGE_ONLY];
            osc_startup_delay <= choices_reg[OPT_DLY];
            watchdog_rate <= choices_reg[OPT_CR_LO+1:OPT_CR_LO];
            converter_power_up <= choices_reg[OPT_CONVERTER_POWER_UP];
            pump_clock_alt <= choices_reg[OPT_ALT_CLOCK_SELECT];
            adc_clock_alt <= choices_reg[OPT_ALT_CLOCK_SELECT];
            special_mode_flag <= special_reg;
            {ram_sel, reg_sel, rom_sel, nvm_sel, ext_sel} <=
                {ram_sel_d, reg_sel_d, rom_sel_d, nvm_sel_d, ext_sel_d};
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_latch_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> $stable(setup_latch_reg))
        else $error("setup latches changed outside reset");
    chk_setup_read: assert property (@(posedge aclk) disable iff (!aresetn)
        rvalid_reg && rd_setup_reg && $stable(setup_latch_reg) |-> rdata_reg[7:0] == setup_latch_reg)
        else $error("setup read did not return latches");
    chk_rom_forced: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && single_chip |=> rom_in_map)
        else $error("rom left map in single-chip mode");
    chk_sec_no_option: assert property (@(posedge aclk) disable iff (!aresetn)
        !SECURITY_OPTION |-> setup_latch_reg[SETUP_SEC_DIS])
        else $error("security disable not 1 without option");
    chk_placement_lock: assert property (@(posedge aclk) disable iff (!aresetn)
        !special_reg && (!window_open || placement_done_reg) |=> $stable(placement_reg))
        else $error("placement changed after lock");
    chk_choices_lock: assert property (@(posedge aclk) disable iff (!aresetn)
        !special_reg && !window_open |=> $stable(choices_reg & CHOICES_PROTECTED))
        else $error("protected options changed after window");
    chk_placement_reset: assert property (@(posedge aclk)
        $rose(aresetn) |-> placement_reg == PLACEMENT_RESET && cycle_cnt_reg == 7'h00)
        else $error("placement reset value wrong");
    chk_special_latch: assert property (@(posedge aclk)
        $rose(aresetn) |-> special_reg == !$past(boot_b_s2_reg))
        else $error("special flag not inverse of boot pin");
    chk_clock_pair: assert property (@(posedge aclk) disable iff (!aresetn)
        ce ##1 $past(aresetn) |-> pump_clock_alt == $past(choices_reg[OPT_ALT_CLOCK_SELECT])
            && adc_clock_alt == pump_clock_alt)
        else $error("alternate clock selects disagree");
    chk_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        !REMAP_VARIANT |-> setup_latch_reg[7:4] == 4'h0)
        else $error("unimplemented setup bits not zero");

endmodule

//--- design/setup_latch_pkg.sv
// Purpose: shared constants for the startup setup latches and memory map control
// Assumes: register indices are word indices; byte address is four times the index
// Notes: register offsets, register reset values and the window cycle count live here; map bases stay in mem_map_decode
package setup_latch_pkg;

    // ------------------------------------------------------------
    // register indices and bus layout
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam logic [13:0] IDX_SETUP = 14'h103F;
    localparam logic [13:0] IDX_PLACEMENT = 14'h103D;
    localparam logic [13:0] IDX_CHOICES = 14'h1039;
    localparam logic [13:0] IDX_STATUS = 14'h1040;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SETUP_NVM_EN = 0;
    localparam int SETUP_ROM_EN = 1;
    localparam int SETUP_WDOG_DIS = 2;
    localparam int SETUP_SEC_DIS = 3;
    localparam int OPT_CR_LO = 0;
    localparam int OPT_CME = 3;
    localparam int OPT_DLY = 4;
    localparam int OPT_IRQ_EDGE_ONLY = 5;
    localparam int OPT_ALT_CLOCK_SELECT = 6;
    localparam int OPT_CONVERTER_POWER_UP = 7;

    // ------------------------------------------------------------
    // reset values, masks and counts
    // ------------------------------------------------------------
    localparam logic [7:0] PLACEMENT_RESET = 8'h01;
    localparam logic [7:0] CHOICES_RESET = 8'h00;
    localparam logic [7:0] CHOICES_PROTECTED = 8'h33;
    localparam logic [7:0] CHOICES_IMPL = 8'hFB;
    localparam logic [7:0] NV_DEFAULT = 8'h0F;
    localparam logic [3:0] PAGE_ALL_ONES = 4'hF;
    localparam int WINDOW_CYCLES = 64;
    localparam logic [6:0] WINDOW_COUNT = 7'(WINDOW_CYCLES);

endpackage

//--- design/mem_map_decode.sv
// Purpose: decodes a processor address into on-chip memory and register selects
// Assumes: priority register block, then RAM, then NVM, then ROM
// Notes: purely combinational; the caller registers the selects
`timescale 1ns/10ps
module mem_map_decode
    import setup_latch_pkg::*;
#(
    parameter logic [15:0] ROM_BASE = 16'hC000,
    parameter logic [15:0] NVM_BASE = 16'hB000,
    parameter int NVM_SIZE = 2048,
    parameter int RAM_SIZE = 256,
    parameter bit REMAP_VARIANT = 1'b0
)
(
    // address and map state
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0] setup_latch,
    input wire logic rom_in_map,
    input wire logic [7:0] placement,
    // selects
    output logic ram_sel,
    output logic reg_sel,
    output logic rom_sel,
    output logic nvm_sel,
    output logic ext_sel
);

    // ------------------------------------------------------------
    // window test
    // ------------------------------------------------------------
    function automatic logic in_window(input logic [15:0] a, input logic [15:0] base,
                                       input logic [16:0] size);
        logic [16:0] off;
        off = {1'b0, a} - {1'b0, base};
        in_window = (a >= base) && (off < size);
    endfunction

    logic [15:0] nvm_base;
    logic ram_hit, reg_hit, nvm_hit, rom_hit;

    always_comb
    begin
        // the remappable part puts nvm at page offset 0x800
        nvm_base = REMAP_VARIANT ? {setup_latch[7:4], 12'h800} : NVM_BASE;
        reg_hit = in_window(cpu_addr, {placement[3:0], 12'h000}, 17'd64);
        ram_hit = in_window(cpu_addr, {placement[7:4], 12'h000}, 17'(RAM_SIZE));
        nvm_hit = setup_latch[SETUP_NVM_EN]
            && in_window(cpu_addr, nvm_base, 17'(NVM_SIZE));
        rom_hit = rom_in_map && (cpu_addr >= ROM_BASE);
        reg_sel = reg_hit;
        ram_sel = ram_hit && !reg_hit;
        nvm_sel = nvm_hit && !reg_hit && !ram_hit;
        rom_sel = rom_hit && !reg_hit && !ram_hit && !nvm_hit;
        ext_sel = !(reg_hit || ram_hit || nvm_hit || rom_hit);
    end

endmodule

//--- tb/system_setup_latches_tb_top.sv
// Purpose: self-checking bench for the startup setup latches and map control
// Assumes: aresetn held 8 cycles; mode pins settle before release
// Notes: model keeps stored byte, latches and write-once state as integers
`timescale 1ns/10ps
module system_setup_latches_tb_top
    import setup_latch_pkg::*;
;
logic aclk, aresetn, ce, por_n, boot_pin_b, mode_pin_a, test_disable_resets;
logic [15:0] cpu_addr, awaddr, araddr;
logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
logic [31:0] wdata, rdata, rd;
logic [3:0] wstrb;
logic [1:0] bresp, rresp, rs, watchdog_rate;
logic rom_in_map, nvm_in_map, security_disable, watchdog_enable, irq_edge_only;
logic osc_startup_delay, converter_power_up, pump_clock_alt, adc_clock_alt;
logic special_mode_flag, ram_sel, reg_sel, rom_sel, nvm_sel, ext_sel;
logic [7:0] d;
int n_errors, compares, cyc, nv, lat, plc, cho, spec, plcd, chod;

system_setup_latches u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .por_n(por_n),
    .boot_pin_b(boot_pin_b), .mode_pin_a(mode_pin_a), .test_disable_resets(test_disable_resets),
    .cpu_addr(cpu_addr), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .rom_in_map(rom_in_map),
    .nvm_in_map(nvm_in_map), .security_disable(security_disable),
    .watchdog_enable(watchdog_enable), .irq_edge_only(irq_edge_only),
    .osc_startup_delay(osc_startup_delay), .watchdog_rate(watchdog_rate),
    .converter_power_up(converter_power_up), .pump_clock_alt(pump_clock_alt),
    .adc_clock_alt(adc_clock_alt), .special_mode_flag(special_mode_flag), .ram_sel(ram_sel),
    .reg_sel(reg_sel), .rom_sel(rom_sel), .nvm_sel(nvm_sel), .ext_sel(ext_sel));

initial
begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
end

// window model counts cycles since reset release
always @(posedge aclk) cyc <= aresetn ? cyc + 1 : 0;

task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
        n_errors++;
        $display("BAD %s exp %h seen %h", nm, e, s);
    end
endtask

task automatic end_sim;
    $display("mismatches %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask

// ----------------------------------------
// reset with mode pins; latches reload
// ----------------------------------------
task automatic rst(input logic b, input logic a);
    @(posedge aclk);
    aresetn <= 1'b0;
    boot_pin_b <= b;
    mode_pin_a <= a;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    lat = (nv & 8'hFB) | ((b ? nv : lat) & 8'h04) | (a ? 8'h08 : 8'h00);
    spec = !b;
    plc = 1;
    cho = 0;
    plcd = 0;
    chod = 0;
    repeat (2) @(posedge aclk);
    // outputs are checked away from the edge that updates them
    @(negedge aclk);
endtask

// ----------------------------------------
// bus tasks: handshakes sampled mid-cycle
// ----------------------------------------
task automatic wr(input logic [13:0] idx, input logic [7:0] v);
    logic ah, wh, bh = 1'b0;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bh)
    begin
        @(negedge aclk);
        ah = awvalid & awready;
        wh = wvalid & wready;
        bh = bvalid;
        rs = bresp;
        @(posedge aclk);
        if (ah) awvalid <= 1'b0;
        if (wh) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk("bresp", rs, (idx inside {IDX_SETUP, IDX_PLACEMENT, IDX_CHOICES, IDX_STATUS}) ?
        RESP_OKAY : RESP_SLVERR);
    if (idx == IDX_SETUP) nv = v;
    if (idx == IDX_PLACEMENT && (spec || (!plcd && cyc < 64)))
    begin
        plc = v;
        plcd = 1;
    end
    if (idx == IDX_CHOICES)
    begin
        if (spec || (!chod && cyc < 64))
        begin
            cho = (cho & 8'hCC) | (v & 8'h33);
            chod = 1;
        end
        cho = (cho & 8'h33) | (v & 8'hC8);
    end
endtask

task automatic rc(input logic [13:0] idx);
    logic ah, rh = 1'b0;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rh)
    begin
        @(negedge aclk);
        ah = arvalid & arready;
        rh = rvalid;
        rd = rdata;
        @(posedge aclk);
        if (ah) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk("rdata", rd, idx == IDX_SETUP ? lat & 8'h0F : idx == IDX_PLACEMENT ? plc : cho);
endtask

task automatic sel(input logic [15:0] a, input logic r, input logic m, input logic [2:0] o);
    @(posedge aclk);
    cpu_addr <= a;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk("reg_sel", reg_sel, r);
    chk("ram_sel", ram_sel, m);
    chk("rom_nvm_ext", {rom_sel, nvm_sel, ext_sel}, o);
endtask

initial
begin
    #60000;
    n_errors++;
    end_sim;
end

initial
begin
    {awvalid, wvalid, bready, arvalid, rready, aresetn, por_n, test_disable_resets} = '0;
    {ce, boot_pin_b, mode_pin_a, wstrb} = {1'b1, 1'b1, 1'b0, 4'hF};
    {awaddr, araddr, wdata, cpu_addr} = '0;
    {n_errors, compares, nv, lat} = {32'd0, 32'd0, 32'h0F, 32'h0F};
    void'($urandom(44094));
    repeat (2) @(posedge aclk);
    por_n <= 1'b1;
    rst(1'b1, 1'b0);
    rc(IDX_PLACEMENT);
    rc(IDX_CHOICES);
    rc(IDX_SETUP);
    sel(16'h1020, 1'b1, 1'b0, 3'b000);
    sel(16'h0010, 1'b0, 1'b1, 3'b000);
    $display("reset values done");
    d = 8'($urandom);
    wr(IDX_PLACEMENT, d);
    rc(IDX_PLACEMENT);
    wr(IDX_PLACEMENT, ~d);
    rc(IDX_PLACEMENT);
    sel({d[3:0], 12'h030}, 1'b1, 1'b0, 3'b000);
    sel({d[7:4], 12'h0F0}, 1'b0, 1'b1, 3'b000);
    wr(IDX_CHOICES, 8'hFF);
    rc(IDX_CHOICES);
    wr(IDX_CHOICES, 8'h40);
    rc(IDX_CHOICES);
    @(negedge aclk);
    chk("pump", pump_clock_alt, 1'b1);
    chk("adc", adc_clock_alt, 1'b1);
    chk("rate", watchdog_rate, 2'h3);
    chk("irq", irq_edge_only, cho[5]);
    chk("dly", osc_startup_delay, cho[4]);
    chk("converter_power_up", converter_power_up, cho[7]);
    sel(16'hC100, 1'b0, 1'b0, 3'b100);
    sel(16'hB100, 1'b0, 1'b0, 3'b010);
    sel(16'h8F80, 1'b0, 1'b0, 3'b001);
    $display("window writes done");
    d = 8'($urandom);
    wr(IDX_SETUP, d);
    rc(IDX_SETUP);
    rst(1'b1, 1'b0);
    rc(IDX_SETUP);
    chk("nvm", nvm_in_map, lat & 1);
    chk("rom", rom_in_map, 1'b1);
    chk("sec", security_disable, (lat >> 3) & 1);
    rst(1'b1, 1'b1);
    chk("rom", rom_in_map, (lat >> 1) & 1);
    chk("sec", security_disable, 1'b1);
    sel(16'hC100, 1'b0, 1'b0, {lat[1], 1'b0, !lat[1]});
    sel(16'hB100, 1'b0, 1'b0, {1'b0, lat[0], !lat[0]});
    repeat (70) @(posedge aclk);
    wr(IDX_PLACEMENT, 8'h55);
    rc(IDX_PLACEMENT);
    wr(IDX_CHOICES, 8'h33);
    rc(IDX_CHOICES);
    $display("setup and late writes done");
    d = ~d;
    wr(IDX_SETUP, d);
    rst(1'b0, 1'b0);
    chk("special", special_mode_flag, 1'b1);
    rc(IDX_SETUP);
    repeat (70) @(posedge aclk);
    for (int i = 0; i < 2; i++)
    begin
        wr(IDX_PLACEMENT, 8'h23 + 8'(i));
        rc(IDX_PLACEMENT);
        wr(IDX_CHOICES, 8'h11 << i);
        rc(IDX_CHOICES);
        test_disable_resets <= i[0];
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk("wdog", watchdog_enable, !i[0]);
    end
    wr(14'h0100, 8'h5A);
    $display("special mode done");
    end_sim;
end
endmodule
